// >>> hdl/pct_timer.sv
// pct_timer: down-counting timer ticking on the interface clock or prescaler.
// assumes config and preset are stable inputs from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - source select clear: count every interface clock, 13.56 MHz
// - source select set: count on prescaler ticks
// - taps 010b..111b give 1.70 MHz down to 53 kHz
// - source select at bit 2, zero after reset
// - reload at bit 1, reset zero; clear means stop and hold zero
// - reload set: reload preset at expiry and keep counting
// - tap field bits 3..5, reset 000b; 000b 6.78 MHz, 001b 3.39 MHz
// - bit 0 enables the timer, zero after reset
module pct_timer #(
   parameter int CW = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] cfg_word,
   input wire logic [CW-1:0] preset_value,
   output logic [CW-1:0] count_value,
   output logic expired,
   output logic running
);
   pct_pkg::pct_cfg_s cfg_reg;
   pct_pkg::pct_cfg_s cfg_next;
   pct_pkg::pct_state_e state_reg;
   pct_pkg::pct_state_e state_next;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic expired_reg;
   logic expired_next;
   logic pre_tick;
   logic step;
   logic at_one;
   logic running_reg;
   logic running_next;
   logic pre_run;

   // field unpack from the configuration word, one driver for the whole struct
   assign cfg_next = '{
      divider_tap_select: cfg_word[pct_pkg::TAP_MSB:pct_pkg::TAP_LSB],
      clock_source_select: cfg_word[pct_pkg::SRC_BIT],
      auto_reload_on_expiry: cfg_word[pct_pkg::RELOAD_BIT],
      timer_run: cfg_word[pct_pkg::RUN_BIT]
   };

   pct_prescaler #(
      .W(pct_pkg::PRE_W)
   ) u_pre (
      .clk(clk),
      .rst(rst),
      .enable(pre_run),
      .tap(cfg_reg.divider_tap_select),
      .tick(pre_tick)
   );

   // tick select: bypass gives every clock
   // the divider only runs while selected, so each start begins a full tick period
   assign pre_run = cfg_reg.clock_source_select & cfg_reg.timer_run;
   assign step = cfg_reg.clock_source_select ? pre_tick : 1'b1;
   assign at_one = (count_reg == {{(CW-1){1'b0}}, 1'b1});

   // count and state control
   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      expired_next = 1'b0;
      case (state_reg)
         pct_pkg::PCT_IDLE:
         begin
            if (cfg_reg.timer_run)
            begin
               state_next = pct_pkg::PCT_COUNT;
               count_next = preset_value;
            end
         end
         pct_pkg::PCT_COUNT:
         begin
            if (!cfg_reg.timer_run)
               state_next = pct_pkg::PCT_IDLE;
            // a preset of 0 or 1 expires on the first tick
            else if (step && (at_one || count_reg == '0))
            begin
               expired_next = 1'b1;
               if (cfg_reg.auto_reload_on_expiry)
                  count_next = preset_value;
               else
               begin
                  count_next = '0;
                  state_next = pct_pkg::PCT_DONE;
               end
            end
            else if (step)
               count_next = count_reg - {{(CW-1){1'b0}}, 1'b1};
         end
         pct_pkg::PCT_DONE:
         begin
            if (!cfg_reg.timer_run)
               state_next = pct_pkg::PCT_IDLE;
         end
         default:
            state_next = pct_pkg::PCT_IDLE;
      endcase
   end

   // running is registered so the output comes straight from a flip-flop
   assign running_next = (state_next == pct_pkg::PCT_COUNT);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_reg <= pct_pkg::CFG_RESET;
         state_reg <= pct_pkg::PCT_IDLE;
         count_reg <= '0;
         expired_reg <= 1'b0;
         running_reg <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         state_reg <= state_next;
         count_reg <= count_next;
         expired_reg <= expired_next;
         running_reg <= running_next;
      end
   end

   assign count_value = count_reg;
   assign expired = expired_reg;
   assign running = running_reg;

   // tick source checks; rate attempts drop out once the tap moves or the divider stops
   bypass_step_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == pct_pkg::PCT_COUNT && cfg_reg.timer_run && !cfg_reg.clock_source_select
      && count_reg > 1 |=> count_reg == $past(count_reg) - 1)
      else $error("bypass count did not step each clock");

   bypass_quiet_a: assert property (@(posedge clk) disable iff (rst)
      !pre_run |=> !pre_tick)
      else $error("prescaler ticked while bypassed");

   pre_hold_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == pct_pkg::PCT_COUNT && cfg_reg.timer_run && cfg_reg.clock_source_select
      && !pre_tick |=> count_reg == $past(count_reg))
      else $error("count moved without prescaler tick");

   tap_rate_a: assert property (@(posedge clk)
      disable iff (rst || !pre_run || cfg_reg.divider_tap_select != 3'h2)
      cfg_reg.clock_source_select && cfg_reg.timer_run && $stable(cfg_reg) && pre_tick
      && cfg_reg.divider_tap_select == 3'h2 |=> !pre_tick [*7] ##1 pre_tick)
      else $error("tap 2 tick spacing wrong");

   tap1_rate_a: assert property (@(posedge clk)
      disable iff (rst || !pre_run || cfg_reg.divider_tap_select != 3'h1)
      $stable(cfg_reg) && pre_tick |=> !pre_tick [*3] ##1 pre_tick)
      else $error("tap 1 tick spacing wrong");

   // reset values and field placement
   reset_cfg_a: assert property (@(posedge clk)
      $fell(rst) |-> cfg_reg.clock_source_select == 1'b0 && cfg_reg.timer_run == 1'b0)
      else $error("config not cleared by reset");

   tap_field_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> cfg_reg.divider_tap_select == $past(cfg_word[5:3]))
      else $error("tap field misplaced");

   // start, stop and counting
   start_load_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == pct_pkg::PCT_IDLE && cfg_reg.timer_run
      |=> running && count_reg == $past(preset_value))
      else $error("start did not load preset");

   idle_hold_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == pct_pkg::PCT_IDLE && !cfg_reg.timer_run |=> count_reg == $past(count_reg))
      else $error("idle count moved");

   disabled_idle_a: assert property (@(posedge clk) disable iff (rst)
      !cfg_reg.timer_run |=> !running)
      else $error("timer ran while disabled");

   count_dec_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == pct_pkg::PCT_COUNT && cfg_reg.timer_run && step && count_reg > 1
      |=> count_reg == $past(count_reg) - 1)
      else $error("count did not step by one");

   expiry_pulse_a: assert property (@(posedge clk) disable iff (rst)
      running && cfg_reg.timer_run && step && count_reg == 1 |=> expired)
      else $error("expiry missed at zero");

   expiry_src_a: assert property (@(posedge clk) disable iff (rst)
      expired |-> $past(state_reg) == pct_pkg::PCT_COUNT && $past(step))
      else $error("expiry without a counting tick");

   // one-shot and reload endings
   stop_hold_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == pct_pkg::PCT_DONE && cfg_reg.timer_run |=> count_reg == '0)
      else $error("one-shot timer left zero");

   done_hold_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == pct_pkg::PCT_DONE && cfg_reg.timer_run |=> state_reg == pct_pkg::PCT_DONE)
      else $error("one-shot timer restarted");

   oneshot_stop_a: assert property (@(posedge clk) disable iff (rst)
      expired && !$past(cfg_reg.auto_reload_on_expiry) |-> count_reg == '0 && !running)
      else $error("one-shot timer kept counting");

   reload_preset_a: assert property (@(posedge clk) disable iff (rst)
      expired && $past(cfg_reg.auto_reload_on_expiry) && $past(cfg_reg.timer_run)
      |-> count_reg == $past(preset_value) && running)
      else $error("reload did not restore preset");

   // main scenarios
   cover_oneshot_c: cover property (@(posedge clk) state_reg == pct_pkg::PCT_DONE);
   cover_reload_c: cover property (@(posedge clk) expired && running);
   cover_pre_c: cover property (@(posedge clk) running && cfg_reg.clock_source_select && pre_tick);
   cover_tap7_c: cover property (@(posedge clk) pre_run && cfg_reg.divider_tap_select == 3'h7
      && pre_tick);
   cover_start_c: cover property (@(posedge clk) state_reg == pct_pkg::PCT_IDLE
      && cfg_reg.timer_run);
endmodule : pct_timer
`default_nettype wire

// >>> hdl/pct_pkg.sv
// pct_pkg: constants and carrier types for the prescaled countdown timer.
// assumes one clock domain, the contactless interface clock.
`default_nettype none
package pct_pkg;
   // configuration word layout
   localparam int RUN_BIT = 0;
   localparam int RELOAD_BIT = 1;
   localparam int SRC_BIT = 2;
   localparam int TAP_LSB = 3;
   localparam int TAP_MSB = 5;
   localparam logic [5:0] CFG_RESET = 6'h00;
   // clock rate figures, in kHz
   localparam int IFACE_CLK_KHZ = 13560;
   localparam int TAP0_KHZ = 6780;
   // prescaler width: 13.56 MHz / 53 kHz = 256 clocks per slowest tick
   localparam int PRE_W = 8;
   localparam logic [PRE_W-1:0] PRE_RESET = 8'h00;

   typedef struct packed {
      logic [2:0] divider_tap_select;
      logic clock_source_select;
      logic auto_reload_on_expiry;
      logic timer_run;
   } pct_cfg_s;

   typedef enum logic [1:0] {
      PCT_IDLE = 2'b00,
      PCT_COUNT = 2'b01,
      PCT_DONE = 2'b11
   } pct_state_e;
endpackage : pct_pkg
`default_nettype wire

// >>> hdl/pct_prescaler.sv
// pct_prescaler: enable-gated divider of the interface clock giving one-cycle ticks.
// assumes clk is the contactless interface clock.
`timescale 1ns/1ps
`default_nettype none
module pct_prescaler #(
   parameter int W = pct_pkg::PRE_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [2:0] tap,
   output logic tick
);
   logic [W-1:0] div_reg;
   logic [W-1:0] div_next;
   logic tick_reg;
   logic tick_next;
   logic [W-1:0] carry;

   // divider runs only while the prescaler is selected
   assign div_next = enable ? div_reg + {{(W-1){1'b0}}, 1'b1} : W'(pct_pkg::PRE_RESET);

   // tap k ticks every 2^(k+1) clocks: bit k wraps to zero
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_carry
         assign carry[i] = &div_reg[i:0];
      end
   endgenerate
   assign tick_next = enable & carry[tap];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div_reg <= W'(pct_pkg::PRE_RESET);
         tick_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_next;
         tick_reg <= tick_next;
      end
   end
   assign tick = tick_reg;

   // tap 0 ticks every second clock; dropped once the divider stops or the tap moves
   tap0_rate_a: assert property (@(posedge clk) disable iff (rst || !enable || tap != 3'h0)
      $past(enable) && $stable(tap) && tick |=> !tick ##1 tick)
      else $error("tap 0 tick spacing wrong");
endmodule : pct_prescaler
`default_nettype wire

// >>> tb/pct_timer_tb_top.sv
// pct_timer_tb_top: self-checking bench for the countdown timer.
// assumes the timer and its package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_errors++; \
   $display("unexpected %s exp %0h got %0h", n, e, s); end end
module pct_timer_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   pct_pkg::pct_cfg_s cfg = '0;
   logic [19:0] preset_value = 20'h00000;
   logic [19:0] count_value;
   logic expired;
   logic running;
   int n_errors = 0;
   int cmp_count = 0;
   // unit under test
   pct_timer #(.CW(20)) dut_u (.clk(clk), .rst(rst), .cfg_word(cfg),
      .preset_value(preset_value), .count_value(count_value),
      .expired(expired), .running(running));
   // 100 mhz clock
   always #5 clk = ~clk;
   // step n edges, then settle
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // bounded wait for the timer to start
   task automatic wait_run();
      int i;
      for (i = 0; i < 10 && running !== 1'b1; i++) tick(1);
   endtask : wait_run
   // stop the timer and let it settle
   task automatic stop();
      cfg.timer_run = 1'b0;
      tick(4);
   endtask : stop
   // outputs quiet after reset, defaults leave it idle
   task automatic t_reset();
      `CHK("count", 20'h00000, count_value)
      `CHK("running", 1'b0, running)
      `CHK("expired", 1'b0, expired)
   endtask : t_reset
   // one-shot in bypass: one step per clock, stop and hold zero
   task automatic t_oneshot();
      preset_value = 20'h00003;
      cfg = 6'h01;
      wait_run();
      `CHK("start count", 20'h00003, count_value)
      tick(1);
      `CHK("count 2", 20'h00002, count_value)
      tick(1);
      `CHK("count 1", 20'h00001, count_value)
      tick(1);
      `CHK("expiry", 1'b1, expired)
      `CHK("zero", 20'h00000, count_value)
      `CHK("stopped", 1'b0, running)
      tick(5);
      `CHK("held zero", 20'h00000, count_value)
      `CHK("pulse gone", 1'b0, expired)
      stop();
   endtask : t_oneshot
   // auto reload: preset back on expiry, still running
   task automatic t_reload();
      preset_value = 20'h00002;
      cfg = 6'h03;
      wait_run();
      tick(2);
      `CHK("reload expiry", 1'b1, expired)
      `CHK("reloaded", 20'h00002, count_value)
      `CHK("still running", 1'b1, running)
      tick(1);
      `CHK("counts on", 20'h00001, count_value)
      tick(1);
      `CHK("second expiry", 1'b1, expired)
      stop();
   endtask : t_reload
   // prescaled tick spacing for one tap code
   task automatic t_tap(input logic [2:0] k);
      int n;
      logic [19:0] v;
      preset_value = 20'h00008;
      cfg = {k, 3'b101};
      wait_run();
      `CHK("tap start", 20'h00008, count_value)
      for (n = 0; n < 600 && count_value === 20'h00008; n++) tick(1);
      v = count_value;
      for (n = 0; n < 600 && count_value === v; n++) tick(1);
      `CHK("tap spacing", 1 << (k + 1), n)
      stop();
   endtask : t_tap
   // verdict
   task automatic final_report();
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   // watchdog against a hung wait
   initial
   begin
      #300000;
      n_errors++;
      final_report();
   end
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      tick(1);
      t_reset();
      t_oneshot();
      t_reload();
      for (int k = 0; k < 8; k++) t_tap(k[2:0]);
      final_report();
   end
endmodule : pct_timer_tb_top
`default_nettype wire
